// [verilog/tzs_pkg.sv]
// constants and types for the zone status flag generator
// assumes a single 125 MHz clock shared with the backplane exchange logic
package tzs_pkg;

    // ------------------------------------------------------------------
    // exchange sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHAN = 8;
    localparam int CHAN_BITS = 7;
    localparam int IMAGE_BITS = 64;
    localparam int CMD_BITS = 24;
    localparam int FEEDBACK_WORDS = 28;
    localparam int PARAM_WORDS = 3;
    localparam int WORD_BITS = 16;
    localparam int FEEDBACK_ERR_WORD = 28;

    // ------------------------------------------------------------------
    // field positions inside one channel group
    // ------------------------------------------------------------------
    localparam int FLD_UPPER_ALARM = 0;
    localparam int FLD_LOWER_ALARM = 1;
    localparam int FLD_UPPER_DEV = 2;
    localparam int FLD_LOWER_DEV = 3;
    localparam int FLD_SENSOR_FAULT_LOW = 4;
    localparam int FLD_OUT_SHORT = 5;
    localparam int FLD_ZONE_ERR = 6;

    // ------------------------------------------------------------------
    // image positions, index = documented bit number minus one
    // ------------------------------------------------------------------
    localparam int IMG_CHAN_BASE = 0;
    localparam int IMG_COMP_SENSOR = 56;
    localparam int IMG_SPARE_A = 57;
    localparam int IMG_AUTOTUNE = 58;
    localparam int IMG_CALIB = 59;
    localparam int IMG_HEARTBEAT = 60;
    localparam int IMG_SPARE_B = 61;
    localparam int IMG_SUPPLY_FAIL = 62;
    localparam int IMG_GEN_ERR = 63;
    localparam logic [63:0] STATUS_RESET = 64'h0;

    // ------------------------------------------------------------------
    // command bit positions, index = documented bit number minus one
    // ------------------------------------------------------------------
    localparam int CMD_AUTOTUNE_GO = 19;
    localparam int CMD_CAL_INHIBIT = 21;
    localparam int CMD_AUTOTUNE_CANCEL = 23;

    // ------------------------------------------------------------------
    // temperatures in tenths of a degree, signed
    // ------------------------------------------------------------------
    typedef logic signed [15:0] tzs_temp_t;
    localparam tzs_temp_t TEMP_MAX = 16'sh7FFF;
    localparam tzs_temp_t COMP_MIN_TENTHS = 16'sh0000;
    localparam tzs_temp_t COMP_MAX_TENTHS = 16'sh0258;
    localparam logic signed [16:0] CAL_DRIFT_TENTHS = 17'sh00020;

    // ------------------------------------------------------------------
    // sensor fault pair {zone, low}
    // ------------------------------------------------------------------
    localparam logic [1:0] FAULT_NONE = 2'h0;
    localparam logic [1:0] FAULT_OPEN = 2'h1;
    localparam logic [1:0] FAULT_REVERSED = 2'h3;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int CAL_TIME_MS = 3000;
    localparam int CAL_CYCLES = CAL_TIME_MS * 1000 * CLK_MHZ;

    // pin bundle: shorts, opens, reversals, compensation fault, supply ok
    localparam int SYNC_BITS = 3 * NUM_CHAN + 2;

    typedef enum {CAL_IDLE, CAL_RUN} tzs_cal_state_t;

endpackage

// [verilog/tzs_status_flags.sv]
// status image generator for an eight zone temperature module
// assumes field fault pins are asynchronous; host command, scan strobe,
// temperatures and thresholds come from logic on sys_clk
//
// Behaviour
// - seven bits per channel, channel one first
// - upper alarm when temperature above upper alarm
// - lower alarm when temperature below lower alarm
// - upper deviation when above deviation band top
// - lower deviation when below deviation band bottom
// - fault pair 00 none, 01 open, 11 reversed
// - output short flag follows driver short detect
// - bit 57 on compensation sensor short/open
// - bit 59 while autotuning, clears when reported
// - bit 60 during three second calibration, measurement frozen
// - command bit 22 blocks calibration entry
// - bit 61 heartbeat, module running normally
// - bit 63 when external supply missing
// - bit 64 on fault, code in word 28
// - higher priority errors mask lower ones
// - image exchanged with host every scan
// - calibrate when internal temperature drifts over 3.2
// - open sensor or bad compensation reports maximum
`timescale 1ns/1ps

module tzs_status_flags #(
    parameter int CAL_CYCLES_P = tzs_pkg::CAL_CYCLES // calibration length in clocks
) (
    input wire logic sys_clk, // 125 MHz
    input wire logic sys_rst, // synchronous, active high
    input wire logic scanStrobe, // one pulse per host scan
    input wire logic [tzs_pkg::CMD_BITS-1:0] cmdBits, // host command bits
    input wire tzs_pkg::tzs_temp_t chanTemp [tzs_pkg::NUM_CHAN], // measured temps
    input wire tzs_pkg::tzs_temp_t upperAlarm [tzs_pkg::NUM_CHAN], // alarm high limit
    input wire tzs_pkg::tzs_temp_t lowerAlarm [tzs_pkg::NUM_CHAN], // alarm low limit
    input wire tzs_pkg::tzs_temp_t upperDev [tzs_pkg::NUM_CHAN], // band top
    input wire tzs_pkg::tzs_temp_t lowerDev [tzs_pkg::NUM_CHAN], // band bottom
    input wire tzs_pkg::tzs_temp_t compTemp, // compensation temperature
    input wire tzs_pkg::tzs_temp_t internalTemp, // board temperature
    input wire logic [tzs_pkg::NUM_CHAN-1:0] outShortPin, // driver short, async
    input wire logic [tzs_pkg::NUM_CHAN-1:0] sensorOpenPin, // open sensor, async
    input wire logic [tzs_pkg::NUM_CHAN-1:0] sensorRevPin, // reversed sensor, async
    input wire logic compSensorFaultPin, // compensation short/open, async
    input wire logic supplyOkPin, // external supply present, async
    input wire logic hwFault, // hardware fault seen
    input wire logic paramError, // parameter out of range
    input wire logic [tzs_pkg::WORD_BITS-1:0] errCode, // detailed error code
    input wire logic tuneReportDone, // pulse: all tuned sets reported
    output logic [tzs_pkg::IMAGE_BITS-1:0] statusImage, // status image to host
    output tzs_pkg::tzs_temp_t chanTempReport [tzs_pkg::NUM_CHAN], // reported temps
    output logic [tzs_pkg::WORD_BITS-1:0] errorCodeWord // feedback word 28
);
    import tzs_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [SYNC_BITS-1:0] pinMeta_reg;
    logic [SYNC_BITS-1:0] pinSync_reg;
    logic [SYNC_BITS-1:0] pinRaw;

    assign pinRaw = {supplyOkPin, compSensorFaultPin, sensorRevPin, sensorOpenPin, outShortPin};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
        end else begin
            pinMeta_reg <= pinRaw;
            pinSync_reg <= pinMeta_reg;
        end
    end

    logic [NUM_CHAN-1:0] shortS;
    logic [NUM_CHAN-1:0] openS;
    logic [NUM_CHAN-1:0] revS;
    logic compFaultS;
    logic supplyFailS;

    assign shortS = pinSync_reg[NUM_CHAN-1:0];
    assign openS = pinSync_reg[2*NUM_CHAN-1:NUM_CHAN];
    assign revS = pinSync_reg[3*NUM_CHAN-1:2*NUM_CHAN];
    assign compFaultS = pinSync_reg[3*NUM_CHAN];
    assign supplyFailS = ~pinSync_reg[3*NUM_CHAN+1];

    // ------------------------------------------------------------------
    // compensation range
    // ------------------------------------------------------------------
    logic compRangeBad;

    assign compRangeBad = (compTemp < COMP_MIN_TENTHS) || (compTemp > COMP_MAX_TENTHS);

    // ------------------------------------------------------------------
    // per channel flag decode
    // ------------------------------------------------------------------
    // priority chain: supply, compensation range, sensor fault, upper alarm,
    // upper deviation, lower alarm, lower deviation; short is never masked
    function automatic logic [CHAN_BITS-1:0] chanFlags(
        input tzs_temp_t temp,
        input tzs_temp_t upAlm,
        input tzs_temp_t loAlm,
        input tzs_temp_t upBand,
        input tzs_temp_t loBand,
        input logic sensOpen,
        input logic sensRev,
        input logic outShort,
        input logic supplyFail,
        input logic compBad
    );
        logic [CHAN_BITS-1:0] f;
        logic [1:0] code;
        logic masked;
        logic upA;
        logic upD;
        logic loA;
        f = '0;
        code = sensRev ? FAULT_REVERSED : (sensOpen ? FAULT_OPEN : FAULT_NONE);
        masked = supplyFail | compBad;
        upA = temp > upAlm;
        upD = temp > upBand;
        loA = temp < loAlm;
        if (!masked) begin
            f[FLD_SENSOR_FAULT_LOW] = code[0];
            f[FLD_ZONE_ERR] = code[1];
            if (code == FAULT_NONE) begin
                f[FLD_UPPER_ALARM] = upA;
                f[FLD_UPPER_DEV] = upD && !upA;
                f[FLD_LOWER_ALARM] = loA && !upA && !upD;
                f[FLD_LOWER_DEV] = (temp < loBand) && !upA && !upD && !loA;
            end
        end
        f[FLD_OUT_SHORT] = outShort;
        return f;
    endfunction

    logic [NUM_CHAN*CHAN_BITS-1:0] chanField;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            assign chanField[gi*CHAN_BITS +: CHAN_BITS] = chanFlags(
                chanTemp[gi], upperAlarm[gi], lowerAlarm[gi], upperDev[gi],
                lowerDev[gi], openS[gi], revS[gi], shortS[gi], supplyFailS,
                compRangeBad);
        end
    endgenerate

    // ------------------------------------------------------------------
    // calibration sequencing
    // ------------------------------------------------------------------
    tzs_cal_state_t calState_reg;
    tzs_cal_state_t calState_next;
    logic [31:0] calCount_reg;
    tzs_temp_t calRef_reg;
    logic calRefValid_reg;
    logic signed [16:0] drift;
    logic driftBig;
    logic calDone;

    assign drift = 17'(internalTemp) - 17'(calRef_reg);
    assign driftBig = calRefValid_reg
        && ((drift > CAL_DRIFT_TENTHS) || (drift < -CAL_DRIFT_TENTHS));
    assign calDone = calCount_reg == 32'(CAL_CYCLES_P - 1);

    always_comb begin
        calState_next = calState_reg;
        case (calState_reg)
            CAL_IDLE: begin
                if (driftBig && !cmdBits[CMD_CAL_INHIBIT]) begin
                    calState_next = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (calDone) begin
                    calState_next = CAL_IDLE;
                end
            end
            default: calState_next = CAL_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            calState_reg <= CAL_IDLE;
        end else begin
            calState_reg <= calState_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || calState_reg != CAL_RUN) begin
            calCount_reg <= 32'h0;
        end else begin
            calCount_reg <= calCount_reg + 32'h1;
        end
    end

    // reference caught after reset release, then re-taken on each calibration
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            calRef_reg <= 16'sh0000;
            calRefValid_reg <= 1'b0;
        end else if (!calRefValid_reg || (calState_reg == CAL_RUN && calDone)) begin
            calRef_reg <= internalTemp;
            calRefValid_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // reported temperatures, frozen while calibrating
    // ------------------------------------------------------------------
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_temp
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    chanTempReport[gi] <= 16'sh0000;
                end else if (calState_reg != CAL_RUN) begin
                    chanTempReport[gi] <= (openS[gi] || compRangeBad) ? TEMP_MAX
                                                                       : chanTemp[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // autotuning flag
    // ------------------------------------------------------------------
    logic autoOn_reg;
    logic goPrev_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            goPrev_reg <= 1'b0;
        end else begin
            goPrev_reg <= cmdBits[CMD_AUTOTUNE_GO];
        end
    end

    // cancel beats a fresh request; a fresh request beats completion
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            autoOn_reg <= 1'b0;
        end else if (cmdBits[CMD_AUTOTUNE_CANCEL]) begin
            autoOn_reg <= 1'b0;
        end else if (cmdBits[CMD_AUTOTUNE_GO] && !goPrev_reg) begin
            autoOn_reg <= 1'b1;
        end else if (tuneReportDone || !cmdBits[CMD_AUTOTUNE_GO]) begin
            autoOn_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // image assembly, latched once per scan
    // ------------------------------------------------------------------
    logic [IMAGE_BITS-1:0] imageNext;
    logic genErr;

    assign genErr = hwFault | paramError;

    always_comb begin
        imageNext = STATUS_RESET;
        imageNext[IMG_CHAN_BASE +: NUM_CHAN*CHAN_BITS] = chanField;
        imageNext[IMG_COMP_SENSOR] = compFaultS;
        imageNext[IMG_SPARE_A] = 1'b0;
        imageNext[IMG_AUTOTUNE] = autoOn_reg;
        imageNext[IMG_CALIB] = calState_reg == CAL_RUN;
        imageNext[IMG_HEARTBEAT] = !genErr;
        imageNext[IMG_SPARE_B] = 1'b0;
        imageNext[IMG_SUPPLY_FAIL] = supplyFailS;
        imageNext[IMG_GEN_ERR] = genErr && !supplyFailS;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            statusImage <= STATUS_RESET;
        end else if (scanStrobe) begin
            statusImage <= imageNext;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            errorCodeWord <= '0;
        end else if (scanStrobe) begin
            errorCodeWord <= genErr ? errCode : '0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_spare;
        @(posedge sys_clk) disable iff (sys_rst)
        !statusImage[IMG_SPARE_A] && !statusImage[IMG_SPARE_B];
    endproperty
    a_spare: assert property (p_spare) else $error("spare image bit set");

    property p_supply_mask;
        @(posedge sys_clk) disable iff (sys_rst)
        scanStrobe && supplyFailS |=> statusImage[IMG_SUPPLY_FAIL] && !statusImage[0]
            && !statusImage[4] && !statusImage[IMG_GEN_ERR];
    endproperty
    a_supply_mask: assert property (p_supply_mask) else $error("supply fail not masking");

    property p_upper_alarm;
        @(posedge sys_clk) disable iff (sys_rst)
        scanStrobe && !supplyFailS && !compRangeBad && !openS[0] && !revS[0]
            && (chanTemp[0] > upperAlarm[0]) |=> statusImage[0] && !statusImage[1];
    endproperty
    a_upper_alarm: assert property (p_upper_alarm) else $error("upper alarm wrong");

    property p_lower_alarm;
        @(posedge sys_clk) disable iff (sys_rst)
        scanStrobe && !supplyFailS && !compRangeBad && !openS[7] && !revS[7]
            && (chanTemp[7] < lowerAlarm[7]) && (chanTemp[7] <= upperAlarm[7])
            && (chanTemp[7] <= upperDev[7]) |=> statusImage[50] && !statusImage[52];
    endproperty
    a_lower_alarm: assert property (p_lower_alarm) else $error("lower alarm wrong");

    property p_reversed;
        @(posedge sys_clk) disable iff (sys_rst)
        scanStrobe && !supplyFailS && !compRangeBad && revS[1]
            |=> statusImage[11] && statusImage[13] && !statusImage[7];
    endproperty
    a_reversed: assert property (p_reversed) else $error("reversed code wrong");

    property p_short;
        @(posedge sys_clk) disable iff (sys_rst)
        scanStrobe && shortS[2] |=> statusImage[19];
    endproperty
    a_short: assert property (p_short) else $error("short flag missing");

    property p_cal_inhibit;
        @(posedge sys_clk) disable iff (sys_rst)
        calState_reg == CAL_IDLE && cmdBits[CMD_CAL_INHIBIT] |=> calState_reg == CAL_IDLE;
    endproperty
    a_cal_inhibit: assert property (p_cal_inhibit) else $error("calibration entered");

    property p_cal_freeze;
        @(posedge sys_clk) disable iff (sys_rst)
        calState_reg == CAL_RUN ##1 calState_reg == CAL_RUN
            |-> chanTempReport[0] == $past(chanTempReport[0]);
    endproperty
    a_cal_freeze: assert property (p_cal_freeze) else $error("temp moved in calibration");

    property p_tune_cancel;
        @(posedge sys_clk) disable iff (sys_rst)
        // image bit only refreshes on an edge that saw a strobe
        cmdBits[CMD_AUTOTUNE_CANCEL]
            |=> !autoOn_reg ##1 (!$past(scanStrobe) || !statusImage[IMG_AUTOTUNE]);
    endproperty
    a_tune_cancel: assert property (p_tune_cancel) else $error("autotune not cancelled");

    property p_open_max;
        @(posedge sys_clk) disable iff (sys_rst)
        calState_reg != CAL_RUN && openS[3] |=> chanTempReport[3] == TEMP_MAX;
    endproperty
    a_open_max: assert property (p_open_max) else $error("open sensor not at max");

    property p_err_word;
        @(posedge sys_clk) disable iff (sys_rst)
        scanStrobe && hwFault
            |=> errorCodeWord == $past(errCode) && statusImage[IMG_HEARTBEAT] == 1'b0;
    endproperty
    a_err_word: assert property (p_err_word) else $error("error word not captured");

endmodule // tzs_status_flags

// [dv/tzs_host_model.sv]
// host side of the per-scan exchange: scan strobe, command bits, readback
// assumes the bench calls its tasks; everything moves at the falling edge
`timescale 1ns/1ps

module tzs_host_model (
    input wire logic sys_clk, // 125 MHz
    output logic scanStrobe, // one pulse per scan
    output logic [tzs_pkg::CMD_BITS-1:0] cmdBits, // command bits
    input wire logic [tzs_pkg::IMAGE_BITS-1:0] statusImage, // image from device
    input wire logic [tzs_pkg::WORD_BITS-1:0] errorCodeWord // feedback word 28
);
    import tzs_pkg::*;
    logic [IMAGE_BITS-1:0] imgSeen;
    logic [WORD_BITS-1:0] codeSeen;

    initial begin
        scanStrobe = 1'b0;
        cmdBits = '0;
    end

    // one scan: single-cycle strobe, whole image read back after the edge
    task automatic scan();
        @(negedge sys_clk);
        scanStrobe = 1'b1;
        @(negedge sys_clk);
        scanStrobe = 1'b0;
        imgSeen = statusImage;
        codeSeen = errorCodeWord;
    endtask

    task automatic setCmd(input int pos, input logic val);
        @(negedge sys_clk);
        cmdBits[pos] = val;
    endtask
endmodule // tzs_host_model

// [dv/temp_zone_status_flags_tb_top.sv]
// self-checking bench for the zone status flag generator
// assumes the host model in dv/ and a short calibration length
`timescale 1ns/1ps

module temp_zone_status_flags_tb_top;
    import tzs_pkg::*;
    localparam int CAL_N = 20;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scanStrobe;
    logic [CMD_BITS-1:0] cmdBits;
    tzs_temp_t chanTemp [NUM_CHAN];
    tzs_temp_t upperAlarm [NUM_CHAN];
    tzs_temp_t lowerAlarm [NUM_CHAN];
    tzs_temp_t upperDev [NUM_CHAN];
    tzs_temp_t lowerDev [NUM_CHAN];
    tzs_temp_t chanTempReport [NUM_CHAN];
    tzs_temp_t expRep [NUM_CHAN];
    tzs_temp_t compTemp;
    tzs_temp_t internalTemp;
    logic [NUM_CHAN-1:0] outShortPin, sensorOpenPin, sensorRevPin;
    logic compSensorFaultPin, supplyOkPin, hwFault, paramError, tuneReportDone;
    logic [WORD_BITS-1:0] errCode, errorCodeWord;
    logic [IMAGE_BITS-1:0] statusImage;
    logic [31:0] seed = 32'h3A2E;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;

    always #4 sys_clk = ~sys_clk;

    tzs_status_flags #(.CAL_CYCLES_P(CAL_N)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .scanStrobe(scanStrobe), .cmdBits(cmdBits),
        .chanTemp(chanTemp), .upperAlarm(upperAlarm), .lowerAlarm(lowerAlarm),
        .upperDev(upperDev), .lowerDev(lowerDev), .compTemp(compTemp),
        .internalTemp(internalTemp), .outShortPin(outShortPin),
        .sensorOpenPin(sensorOpenPin), .sensorRevPin(sensorRevPin),
        .compSensorFaultPin(compSensorFaultPin), .supplyOkPin(supplyOkPin),
        .hwFault(hwFault), .paramError(paramError), .errCode(errCode),
        .tuneReportDone(tuneReportDone), .statusImage(statusImage),
        .chanTempReport(chanTempReport), .errorCodeWord(errorCodeWord));

    tzs_host_model i_host (.sys_clk(sys_clk), .scanStrobe(scanStrobe), .cmdBits(cmdBits),
        .statusImage(statusImage), .errorCodeWord(errorCodeWord));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // spread around the thresholds so every flag level gets hit
    function automatic tzs_temp_t rt();
        return tzs_temp_t'(rnd() % 32'h4B0) - 16'sh00C8;
    endfunction

    function automatic logic compBad();
        return (compTemp < COMP_MIN_TENTHS) || (compTemp > COMP_MAX_TENTHS);
    endfunction

    function automatic logic [6:0] expChan(int c);
        logic [6:0] g;
        g = '0;
        g[FLD_OUT_SHORT] = outShortPin[c];
        if (!supplyOkPin || compBad()) return g;
        if (sensorOpenPin[c] || sensorRevPin[c]) begin
            g[FLD_SENSOR_FAULT_LOW] = 1'b1;
            g[FLD_ZONE_ERR] = sensorRevPin[c];
        end else if (chanTemp[c] > upperAlarm[c]) g[FLD_UPPER_ALARM] = 1'b1;
        else if (chanTemp[c] > upperDev[c]) g[FLD_UPPER_DEV] = 1'b1;
        else if (chanTemp[c] < lowerAlarm[c]) g[FLD_LOWER_ALARM] = 1'b1;
        else if (chanTemp[c] < lowerDev[c]) g[FLD_LOWER_DEV] = 1'b1;
        return g;
    endfunction

    // spare bits are left at zero here
    function automatic logic [63:0] expImage(logic tune, logic cal);
        logic [63:0] v;
        logic err;
        err = hwFault || paramError;
        v = '0;
        for (int c = 0; c < NUM_CHAN; c++) v[CHAN_BITS*c +: CHAN_BITS] = expChan(c);
        v[IMG_COMP_SENSOR] = compSensorFaultPin;
        v[IMG_AUTOTUNE] = tune;
        v[IMG_CALIB] = cal;
        v[IMG_HEARTBEAT] = !err;
        v[IMG_SUPPLY_FAIL] = !supplyOkPin;
        v[IMG_GEN_ERR] = err && supplyOkPin;
        return v;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] expv);
        n_tests++;
        if (seen !== expv) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic draw();
        logic [31:0] r;
        @(negedge sys_clk);
        for (int c = 0; c < NUM_CHAN; c++) begin
            chanTemp[c] = rt();
            upperAlarm[c] = rt();
            lowerAlarm[c] = rt();
            upperDev[c] = rt();
            lowerDev[c] = rt();
        end
        r = rnd();
        outShortPin = r[7:0];
        sensorOpenPin = 8'(rnd() & rnd() & rnd());
        sensorRevPin = 8'(rnd() & rnd() & rnd());
        compSensorFaultPin = r[8];
        // range edges of the compensation temperature
        case (r[11:9])
            3'h0: compTemp = 16'sh0259;
            3'h1: compTemp = 16'shFFFF;
            3'h2: compTemp = COMP_MAX_TENTHS;
            3'h3: compTemp = COMP_MIN_TENTHS;
            default: compTemp = 16'sh012C;
        endcase
    endtask

    // three edges let the pin synchronisers settle before the strobe
    task automatic settleScan(input logic tune, input logic cal);
        repeat (3) @(negedge sys_clk);
        i_host.scan();
        check(i_host.imgSeen, expImage(tune, cal));
        check(64'(i_host.codeSeen), 64'((hwFault || paramError) ? errCode : 16'h0000));
        for (int c = 0; c < NUM_CHAN; c++) begin
            expRep[c] = (sensorOpenPin[c] || compBad()) ? TEMP_MAX : chanTemp[c];
            check(64'(chanTempReport[c]), 64'(expRep[c]));
        end
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            chanTemp[c] = '0;
            upperAlarm[c] = '0;
            lowerAlarm[c] = '0;
            upperDev[c] = '0;
            lowerDev[c] = '0;
        end
        {compTemp, internalTemp, errCode} = '0;
        {outShortPin, sensorOpenPin, sensorRevPin} = '0;
        {compSensorFaultPin, hwFault, paramError, tuneReportDone} = '0;
        supplyOkPin = 1'b1;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        check(statusImage, 64'h0);
        $display("reset test done");
        for (int i = 0; i < 30; i++) begin
            draw();
            settleScan(1'b0, 1'b0);
        end
        $display("random image test done");
        for (int k = 0; k < 8; k++) begin
            draw();
            @(negedge sys_clk);
            hwFault = k[0];
            paramError = k[1];
            supplyOkPin = !k[2];
            compSensorFaultPin = 1'b0;
            errCode = 16'(rnd());
            settleScan(1'b0, 1'b0);
        end
        @(negedge sys_clk);
        {hwFault, paramError, supplyOkPin} = 3'h1;
        $display("error and supply test done");
        // a drift of exactly 3.2 degrees is not enough
        internalTemp = 16'sh0020;
        settleScan(1'b0, 1'b0);
        i_host.setCmd(CMD_CAL_INHIBIT, 1'b1);
        @(negedge sys_clk);
        internalTemp = 16'sh0021;
        settleScan(1'b0, 1'b0);
        i_host.setCmd(CMD_CAL_INHIBIT, 1'b0);
        draw();
        i_host.scan();
        check(64'(i_host.imgSeen[IMG_CALIB]), 64'h1);
        for (int c = 0; c < NUM_CHAN; c++) begin
            check(64'(chanTempReport[c]), 64'(expRep[c]));
        end
        repeat (CAL_N + 4) @(negedge sys_clk);
        settleScan(1'b0, 1'b0);
        $display("calibration test done");
        i_host.setCmd(CMD_AUTOTUNE_GO, 1'b1);
        settleScan(1'b1, 1'b0);
        @(negedge sys_clk);
        tuneReportDone = 1'b1;
        @(negedge sys_clk);
        tuneReportDone = 1'b0;
        settleScan(1'b0, 1'b0);
        i_host.setCmd(CMD_AUTOTUNE_GO, 1'b0);
        i_host.setCmd(CMD_AUTOTUNE_GO, 1'b1);
        settleScan(1'b1, 1'b0);
        i_host.setCmd(CMD_AUTOTUNE_CANCEL, 1'b1);
        settleScan(1'b0, 1'b0);
        $display("autotune test done");
        conclude();
    end
endmodule // temp_zone_status_flags_tb_top
